// >>> bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
    input wire logic clk,
    input wire logic stall,
    input wire logic req_drive,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] dout,
    input wire logic dout_oe,
    output logic req_line,
    output logic wait_n,
    output logic [7:0] din
);
    logic [7:0] mem [16];
    logic [7:0] junk = 8'h00;
    logic [2:0] held = 3'h0;
    // Pulled low; only an enabled driver lifts it
    assign req_line = req_drive;
    // Released bus churns, never keeps the last byte
    assign din = rd_n ? junk : mem[addr];
    // Slow mode holds wait low early in each read
    assign wait_n = !(stall && !rd_n && held != 3'h7);
    always @(posedge clk) begin
        junk <= junk + 8'h3B;
        held <= rd_n ? 3'h0 : held + {2'h0, held != 3'h7};
        if (!wr_n && dout_oe) begin
            mem[addr] <= dout;
        end
    end
endmodule
`default_nettype wire

// >>> cpu_pkg.sv
package cpu_pkg;

    localparam int CLK_PERIOD_NS = 4;

    // Least strobe widths on the bus, rounded up to whole cycles
    localparam int ADDR_STROBE_NS = 20;
    localparam int DATA_STROBE_NS = 40;
    localparam int ADDR_STROBE_CYCLES =
        (ADDR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_STROBE_CYCLES =
        (DATA_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_COUNT_WIDTH = 8;

    localparam int FLAG_LSB = 0;
    localparam int FLAG_WIDTH = 3;
    localparam int INT_ENABLE_BIT = 3;
    localparam int SENSE_A_BIT = 4;
    localparam int SENSE_B_BIT = 5;
    localparam int OVERFLOW_BIT = 6;
    localparam int CARRY_LINK_BIT = 7;

    localparam logic [2:0] FLAGS_RESET = 3'h0;
    localparam logic INT_ENABLE_RESET = 1'h0;
    localparam logic OVERFLOW_RESET = 1'h0;
    localparam logic CARRY_LINK_RESET = 1'h0;
    localparam logic [7:0] EXTENSION_RESET = 8'h00;
    localparam logic SERIAL_OUT_RESET = 1'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] ADDRESS_RESET = 12'h000;

    localparam int SYNC_WIDTH = 8;
    localparam int PIN_RESET_N = 0;
    localparam int PIN_SENSE_A = 1;
    localparam int PIN_SENSE_B = 2;
    localparam int PIN_SERIAL_IN = 3;
    localparam int PIN_RUN_STOP = 4;
    localparam int PIN_BUS_WAIT = 5;
    localparam int PIN_BUS_REQUEST = 6;
    localparam int PIN_GRANT_IN = 7;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_ADD = 4'b0001,
        OP_COMPLEMENT_ADD = 4'b0010,
        OP_DECIMAL_ADD = 4'b0011,
        OP_SHIFT_RIGHT_LINKED = 4'b0100,
        OP_ROTATE_RIGHT_LINKED = 4'b0101,
        OP_INTERRUPT_ENABLE = 4'b0110,
        OP_INTERRUPT_DISABLE = 4'b0111,
        OP_COPY_ACC_TO_STATUS = 4'b1000,
        OP_COPY_STATUS_TO_ACC = 4'b1001,
        OP_SERIAL_SHIFT = 4'b1010,
        OP_EXCHANGE_EXTENSION = 4'b1011
    } op_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_SEEK = 3'b001,
        BUS_ADDR = 3'b010,
        BUS_DATA = 3'b011,
        BUS_DONE = 3'b100
    } bus_state_t;

    typedef struct packed {
        op_t op;
        logic use_extension;
        logic [7:0] acc;
        logic [7:0] operand;
    } op_req_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] status;
    } op_resp_t;

    typedef struct packed {
        logic write;
        logic [3:0] io_status;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

endpackage

// >>> cpu_status_bus.sv
// Notes on behaviour
// - Sense pins read into status bits 4, 5
// - Sense bits read only, never written
// - Interrupt enable op sets bit 3
// - Copy to status loads bit 3
// - Bit 3 set arms sense A interrupt
// - Interrupt disable op clears bit 3
// - Bit 3 clear: sense A plain input
// - Bits 0-2 drive flags, copy writes them
// - Binary and complement adds set overflow
// - Decimal add leaves overflow alone
// - Carry out sets bit 7 on adds
// - Link enters bit 7 on right ops; only rotate loads it from bit 0
// - Link is carry into bit 0
// - Reset pin low aborts operations
// - Serial shift: pin in, LSB to latch
// - Address strobe low only while address valid
// - Data pins: status/address, read, write data
// - Read strobe low, capture at trailing edge
// - Write strobe low only with valid data
// - Address pins hold through the access
// - Seek bus when line low, grant both high
// - Run/stop suspends without losing state
// - Wait input stretches cycles for stepping
`timescale 1ns/10ps
`default_nettype none
module cpu_status_bus (
    input wire logic clk,
    input wire logic reset,
    input wire logic active_low_reset,
    input wire logic sense_a_pin,
    input wire logic sense_b_pin,
    input wire logic serial_in_pin,
    input wire logic run_stop_input,
    input wire logic bus_wait_input,
    input wire logic bus_grant_in,
    input wire logic bus_request_line_in,
    output logic bus_request_line_out,
    output logic bus_request_line_oe,
    output logic bus_grant_out,
    output logic [2:0] flag_pins,
    output logic serial_out_pin,
    output logic interrupt_request,
    output logic address_strobe_n,
    output logic read_strobe_n,
    output logic read_strobe_oe,
    output logic write_strobe_n,
    output logic write_strobe_oe,
    output logic [11:0] address_pins,
    input wire logic [7:0] data_bus_pins_in,
    output logic [7:0] data_bus_pins_out,
    output logic data_bus_pins_oe,
    input wire logic op_valid,
    input wire cpu_pkg::op_req_t op_req,
    output logic op_ready,
    output logic op_done,
    output cpu_pkg::op_resp_t op_resp,
    output logic [7:0] processor_condition_register,
    input wire logic bus_valid,
    input wire cpu_pkg::bus_req_t bus_req,
    output logic bus_ready,
    output logic bus_ack,
    output logic [7:0] bus_rdata
);
    import cpu_pkg::*;

    logic [SYNC_WIDTH-1:0] pins_raw;
    logic [SYNC_WIDTH-1:0] pins_s;
    logic abort;
    logic running;
    logic [2:0] flags_reg;
    logic int_enable_reg;
    logic overflow_reg;
    logic carry_link_reg;
    logic [7:0] extension_reg;
    logic [7:0] status_now;
    logic [7:0] operand;
    logic [8:0] sum;
    logic op_take;
    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;
    logic [BUS_COUNT_WIDTH-1:0] bus_count_reg;
    bus_req_t bus_hold_reg;
    logic count_end;
    logic seeking_reg;

    assign pins_raw = {bus_grant_in, bus_request_line_in, bus_wait_input,
                       run_stop_input, serial_in_pin, sense_b_pin,
                       sense_a_pin, active_low_reset};

    pin_sync #(
        .WIDTH(SYNC_WIDTH)
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .pin_in(pins_raw),
        .level_out(pins_s)
    );

    // Abort lasts until the pin clears the synchroniser
    assign abort = reset || !pins_s[PIN_RESET_N];
    assign running = pins_s[PIN_RUN_STOP];

    function automatic logic [8:0] binary_add(input logic [7:0] a,
                                              input logic [7:0] b,
                                              input logic cin);
        binary_add = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    function automatic logic [8:0] decimal_add(input logic [7:0] a,
                                               input logic [7:0] b,
                                               input logic cin);
        logic [4:0] low;
        logic [4:0] high;
        logic low_carry;
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        low_carry = (low > 5'h09);
        if (low_carry) begin
            low = low + 5'h06;
        end
        high = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low_carry};
        if (high > 5'h09) begin
            high = high + 5'h06;
            decimal_add = {1'b1, high[3:0], low[3:0]};
        end else begin
            decimal_add = {1'b0, high[3:0], low[3:0]};
        end
    endfunction

    function automatic logic signed_overflow(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic [7:0] r);
        signed_overflow = (a[7] == b[7]) && (r[7] != a[7]);
    endfunction

    always_comb begin
        status_now = 8'h00;
        status_now[FLAG_LSB +: FLAG_WIDTH] = flags_reg;
        status_now[INT_ENABLE_BIT] = int_enable_reg;
        status_now[SENSE_A_BIT] = pins_s[PIN_SENSE_A];
        status_now[SENSE_B_BIT] = pins_s[PIN_SENSE_B];
        status_now[OVERFLOW_BIT] = overflow_reg;
        status_now[CARRY_LINK_BIT] = carry_link_reg;
    end

    // Extension form replaces the operand; complement form inverts it
    always_comb begin
        operand = op_req.use_extension ? extension_reg : op_req.operand;
        if (op_req.op == OP_COMPLEMENT_ADD) begin
            operand = ~operand;
        end
        if (op_req.op == OP_DECIMAL_ADD) begin
            sum = decimal_add(op_req.acc, operand, carry_link_reg);
        end else begin
            sum = binary_add(op_req.acc, operand, carry_link_reg);
        end
    end

    assign op_take = op_valid && op_ready;

    always_ff @(posedge clk) begin
        if (abort) begin
            op_ready <= 1'b0;
        end else begin
            op_ready <= running && !op_take;
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            flags_reg <= FLAGS_RESET;
            int_enable_reg <= INT_ENABLE_RESET;
        end else if (op_take) begin
            case (op_req.op)
                OP_INTERRUPT_ENABLE: begin
                    int_enable_reg <= 1'b1;
                end
                OP_INTERRUPT_DISABLE: begin
                    int_enable_reg <= 1'b0;
                end
                OP_COPY_ACC_TO_STATUS: begin
                    int_enable_reg <= op_req.acc[INT_ENABLE_BIT];
                    flags_reg <= op_req.acc[FLAG_LSB +: FLAG_WIDTH];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            overflow_reg <= OVERFLOW_RESET;
            carry_link_reg <= CARRY_LINK_RESET;
        end else if (op_take) begin
            case (op_req.op)
                OP_ADD, OP_COMPLEMENT_ADD: begin
                    carry_link_reg <= sum[8];
                    overflow_reg <= signed_overflow(op_req.acc, operand,
                                                    sum[7:0]);
                end
                OP_DECIMAL_ADD: begin
                    carry_link_reg <= sum[8];
                end
                OP_ROTATE_RIGHT_LINKED: begin
                    carry_link_reg <= op_req.acc[0];
                end
                OP_COPY_ACC_TO_STATUS: begin
                    overflow_reg <= op_req.acc[OVERFLOW_BIT];
                    carry_link_reg <= op_req.acc[CARRY_LINK_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Output latch keeps the shifted-out bit while the register moves on
    always_ff @(posedge clk) begin
        if (abort) begin
            extension_reg <= EXTENSION_RESET;
            serial_out_pin <= SERIAL_OUT_RESET;
        end else if (op_take) begin
            if (op_req.op == OP_SERIAL_SHIFT) begin
                extension_reg <= {pins_s[PIN_SERIAL_IN],
                                  extension_reg[7:1]};
                serial_out_pin <= extension_reg[0];
            end else if (op_req.op == OP_EXCHANGE_EXTENSION) begin
                extension_reg <= op_req.acc;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            op_done <= 1'b0;
            op_resp <= '0;
        end else begin
            op_done <= op_take;
            if (op_take) begin
                op_resp.status <= status_now;
                case (op_req.op)
                    OP_ADD, OP_COMPLEMENT_ADD, OP_DECIMAL_ADD: begin
                        op_resp.acc <= sum[7:0];
                    end
                    OP_SHIFT_RIGHT_LINKED, OP_ROTATE_RIGHT_LINKED: begin
                        op_resp.acc <= {carry_link_reg,
                                        op_req.acc[7:1]};
                    end
                    OP_COPY_STATUS_TO_ACC: begin
                        op_resp.acc <= status_now;
                    end
                    OP_EXCHANGE_EXTENSION: begin
                        op_resp.acc <= extension_reg;
                    end
                    default: begin
                        op_resp.acc <= op_req.acc;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            processor_condition_register <= 8'h00;
            flag_pins <= FLAGS_RESET;
            interrupt_request <= 1'b0;
        end else begin
            processor_condition_register <= status_now;
            flag_pins <= flags_reg;
            // Sense A only requests service while armed
            interrupt_request <= int_enable_reg &&
                                 pins_s[PIN_SENSE_A];
        end
    end

    assign count_end = (bus_count_reg == '0);

    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (bus_valid && bus_ready) begin
                    bus_state_next = BUS_SEEK;
                end
            end
            BUS_SEEK: begin
                if (seeking_reg && pins_s[PIN_BUS_REQUEST] &&
                    pins_s[PIN_GRANT_IN]) begin
                    bus_state_next = BUS_ADDR;
                end
            end
            BUS_ADDR: begin
                if (count_end) begin
                    bus_state_next = BUS_DATA;
                end
            end
            BUS_DATA: begin
                // Wait input low stretches the data phase
                if (count_end && pins_s[PIN_BUS_WAIT]) begin
                    bus_state_next = BUS_DONE;
                end
            end
            BUS_DONE: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            bus_state_reg <= BUS_IDLE;
        end else if (running || bus_state_reg != BUS_IDLE) begin
            bus_state_reg <= bus_state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            bus_count_reg <= '0;
        end else if (bus_state_next == BUS_ADDR &&
                     bus_state_reg != BUS_ADDR) begin
            bus_count_reg <= BUS_COUNT_WIDTH'(ADDR_STROBE_CYCLES - 1);
        end else if (bus_state_next == BUS_DATA &&
                     bus_state_reg != BUS_DATA) begin
            bus_count_reg <= BUS_COUNT_WIDTH'(DATA_STROBE_CYCLES - 1);
        end else if (!count_end) begin
            bus_count_reg <= bus_count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            bus_ready <= 1'b0;
            bus_hold_reg <= '0;
        end else begin
            bus_ready <= running && bus_state_next == BUS_IDLE &&
                         !(bus_valid && bus_ready);
            if (bus_valid && bus_ready) begin
                bus_hold_reg <= bus_req;
            end
        end
    end

    // Seek only after the shared line was seen low, then hold it high
    always_ff @(posedge clk) begin
        if (abort) begin
            seeking_reg <= 1'b0;
        end else if (bus_state_reg == BUS_SEEK && !seeking_reg) begin
            seeking_reg <= !pins_s[PIN_BUS_REQUEST];
        end else if (bus_state_reg == BUS_DONE) begin
            seeking_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            bus_request_line_out <= 1'b0;
            bus_request_line_oe <= 1'b0;
            bus_grant_out <= 1'b0;
        end else begin
            bus_request_line_out <= 1'b1;
            bus_request_line_oe <= seeking_reg && bus_state_next != BUS_IDLE;
            // Pass the grant down the chain when not using the bus
            bus_grant_out <= pins_s[PIN_GRANT_IN] && !seeking_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            address_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            read_strobe_oe <= 1'b0;
            write_strobe_oe <= 1'b0;
        end else begin
            address_strobe_n <= !(bus_state_next == BUS_ADDR);
            read_strobe_n <= !(bus_state_next == BUS_DATA &&
                               !bus_hold_reg.write);
            write_strobe_n <= !(bus_state_next == BUS_DATA &&
                                bus_hold_reg.write);
            read_strobe_oe <= bus_state_next == BUS_ADDR ||
                              bus_state_next == BUS_DATA;
            write_strobe_oe <= bus_state_next == BUS_ADDR ||
                               bus_state_next == BUS_DATA;
        end
    end

    // Address pins stay put until the next address phase
    always_ff @(posedge clk) begin
        if (abort) begin
            address_pins <= ADDRESS_RESET;
        end else if (bus_state_next == BUS_ADDR &&
                     bus_state_reg != BUS_ADDR) begin
            address_pins <= bus_hold_reg.addr[11:0];
        end
    end

    always_ff @(posedge clk) begin
        if (abort) begin
            data_bus_pins_out <= 8'h00;
            data_bus_pins_oe <= 1'b0;
        end else if (bus_state_next == BUS_ADDR) begin
            data_bus_pins_out <= {bus_hold_reg.io_status,
                                  bus_hold_reg.addr[15:12]};
            data_bus_pins_oe <= 1'b1;
        end else if (bus_state_next == BUS_DATA && bus_hold_reg.write) begin
            data_bus_pins_out <= bus_hold_reg.wdata;
            data_bus_pins_oe <= 1'b1;
        end else begin
            data_bus_pins_oe <= 1'b0;
        end
    end

    // Captured in the last strobe cycle: the trailing edge
    always_ff @(posedge clk) begin
        if (abort) begin
            bus_ack <= 1'b0;
            bus_rdata <= 8'h00;
        end else begin
            bus_ack <= bus_state_reg == BUS_DATA &&
                       bus_state_next == BUS_DONE;
            if (bus_state_reg == BUS_DATA && bus_state_next == BUS_DONE &&
                !bus_hold_reg.write) begin
                bus_rdata <= data_bus_pins_in;
            end
        end
    end
endmodule
`default_nettype wire

// >>> cpu_status_bus_props.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_status_bus_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic active_low_reset,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire cpu_pkg::op_req_t op_req,
    input wire logic [7:0] processor_condition_register,
    input wire logic interrupt_request,
    input wire logic [2:0] flag_pins,
    input wire logic address_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic data_bus_pins_oe,
    input wire logic [11:0] address_pins
);
    import cpu_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_take(op_t o);
        op_valid && op_ready && op_req.op == o;
    endsequence
    property p_int_on;
        s_take(OP_INTERRUPT_ENABLE) |->
            ##[1:3] processor_condition_register[3];
    endproperty
    a_int_on: assert property (p_int_on) else $error("bit 3 not set");
    property p_int_off;
        s_take(OP_INTERRUPT_DISABLE) |->
            ##[1:3] !processor_condition_register[3];
    endproperty
    a_int_off: assert property (p_int_off) else $error("bit 3 kept");
    property p_sense_mode;
        !processor_condition_register[3] [*2] |-> !interrupt_request;
    endproperty
    a_sense_mode: assert property (p_sense_mode) else $error("irq");
    property p_abort;
        $fell(active_low_reset) |-> ##[3:8] flag_pins == 3'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missed");
    property p_addr_phase;
        !address_strobe_n |->
            data_bus_pins_oe && read_strobe_n && write_strobe_n;
    endproperty
    a_addr_phase: assert property (p_addr_phase) else $error("address_strobe_n");
    property p_write;
        !write_strobe_n |-> data_bus_pins_oe && address_strobe_n;
    endproperty
    a_write: assert property (p_write) else $error("write undriven");
    property p_read;
        !read_strobe_n |-> !data_bus_pins_oe;
    endproperty
    a_read: assert property (p_read) else $error("read driven");
    property p_hold;
        !read_strobe_n || !write_strobe_n |-> $stable(address_pins);
    endproperty
    a_hold: assert property (p_hold) else $error("address moved");
endmodule
bind cpu_status_bus cpu_status_bus_props props_i (.*);
`default_nettype wire

// >>> cpu_status_bus_test.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_status_bus_test;
    import cpu_pkg::*;
    logic clk, reset, active_low_reset, sense_a_pin, sense_b_pin;
    logic serial_in_pin, run_stop_input, bus_wait_input, bus_grant_in;
    logic bus_request_line_in, bus_request_line_out, bus_request_line_oe;
    logic bus_grant_out, serial_out_pin, interrupt_request, stall;
    logic address_strobe_n, read_strobe_n, read_strobe_oe, write_strobe_n;
    logic write_strobe_oe, data_bus_pins_oe, op_valid, op_ready, op_done;
    logic bus_valid, bus_ready, bus_ack;
    logic [2:0] flag_pins;
    logic [11:0] address_pins;
    logic [7:0] data_bus_pins_in, data_bus_pins_out, bus_rdata, st, q;
    logic [7:0] processor_condition_register;
    op_req_t op_req;
    op_resp_t op_resp, rsp;
    bus_req_t bus_req;
    int error_cnt = 0, tests_run = 0, len;
    cpu_status_bus dut (.*);
    bus_partner far_end (
        .clk, .stall, .req_drive(bus_request_line_oe & bus_request_line_out),
        .rd_n(read_strobe_n | ~read_strobe_oe),
        .wr_n(write_strobe_n | ~write_strobe_oe),
        .addr(address_pins[3:0]), .dout(data_bus_pins_out),
        .dout_oe(data_bus_pins_oe), .req_line(bus_request_line_in),
        .wait_n(bus_wait_input), .din(data_bus_pins_in)
    );
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic lim(input int n);
        if (n >= 900) begin
            error_cnt++;
            $display("[ERR] t=%0t timeout n=%h", $time, n);
            finish_test;
        end
    endtask
    task automatic op(input op_t o, input logic [7:0] a, b);
        int n = 0;
        op_valid <= 1'h1;
        op_req <= '{o, 1'h0, a, b};
        do @(posedge clk); while (op_ready !== 1'h1 && ++n < 900);
        lim(n);
        op_valid <= 1'h0;
        @(posedge clk);
        chk({7'h0, op_done}, 8'h01);
        rsp = op_resp;
        repeat (2) @(posedge clk);
        st = processor_condition_register;
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        int n = 0;
        len = 0;
        bus_valid <= 1'h1;
        bus_req <= '{w, 4'h9, a, d};
        do @(posedge clk); while (bus_ready !== 1'h1 && ++n < 900);
        bus_valid <= 1'h0;
        while (bus_ack !== 1'h1 && ++n < 900) begin
            @(posedge clk);
            if (address_strobe_n === 1'h0) begin
                chk(data_bus_pins_out, {4'h9, a[15:12]});
                chk(address_pins[7:0], a[7:0]);
            end
            if (read_strobe_n === 1'h0) begin
                len++;
            end
        end
        lim(n);
        q = bus_rdata;
        @(posedge clk);
    endtask
    task automatic t_sense_int;
        chk({5'h0, flag_pins}, 8'h00);
        sense_a_pin <= 1'h1;
        repeat (6) @(posedge clk);
        op(OP_INTERRUPT_ENABLE, 8'h00, 8'h00);
        chk(st & 8'h38, 8'h18);
        chk({7'h0, interrupt_request}, 8'h01);
        op(OP_INTERRUPT_DISABLE, 8'h00, 8'h00);
        chk(st & 8'h08, 8'h00);
        chk({7'h0, interrupt_request}, 8'h00);
        sense_a_pin <= 1'h0;
        sense_b_pin <= 1'h1;
        repeat (6) @(posedge clk);
        op(OP_COPY_ACC_TO_STATUS, 8'h1D, 8'h00);
        chk(st, 8'h2D);
        chk({5'h0, flag_pins}, 8'h05);
        op(OP_COPY_ACC_TO_STATUS, 8'h00, 8'h00);
        op(OP_COPY_STATUS_TO_ACC, 8'h00, 8'h00);
        chk(rsp.acc, 8'h20);
        sense_b_pin <= 1'h0;
    endtask
    task automatic t_arith;
        op(OP_ADD, 8'h7F, 8'h01);
        chk(rsp.acc, 8'h80);
        chk(st & 8'hC0, 8'h40);
        op(OP_ADD, 8'hFF, 8'h01);
        chk(rsp.status & 8'hC0, 8'h40);
        chk(st & 8'hC0, 8'h80);
        op(OP_ADD, 8'h00, 8'h00);
        chk(rsp.acc, 8'h01);
        op(OP_COMPLEMENT_ADD, 8'h80, 8'h00);
        chk(rsp.acc, 8'h7F);
        chk(st & 8'hC0, 8'hC0);
        op(OP_DECIMAL_ADD, 8'h45, 8'h54);
        chk(rsp.acc, 8'h00);
        chk(st & 8'hC0, 8'hC0);
        op(OP_ROTATE_RIGHT_LINKED, 8'h01, 8'h00);
        chk(rsp.acc, 8'h80);
        op(OP_SHIFT_RIGHT_LINKED, 8'h04, 8'h00);
        chk(rsp.acc, 8'h82);
        chk(st & 8'h80, 8'h80);
    endtask
    task automatic t_serial;
        op(OP_EXCHANGE_EXTENSION, 8'h01, 8'h00);
        serial_in_pin <= 1'h1;
        repeat (6) @(posedge clk);
        op(OP_SERIAL_SHIFT, 8'h00, 8'h00);
        op(OP_EXCHANGE_EXTENSION, 8'h00, 8'h00);
        chk(rsp.acc, 8'h80);
        chk({7'h0, serial_out_pin}, 8'h01);
    endtask
    task automatic t_bus;
        bus(1'h1, 16'h7A05, 8'hC3);
        stall <= 1'h1;
        bus(1'h0, 16'h7A05, 8'h00);
        stall <= 1'h0;
        chk(q, 8'hC3);
        chk({7'h0, len > DATA_STROBE_CYCLES}, 8'h01);
    endtask
    task automatic t_stop;
        run_stop_input <= 1'h0;
        repeat (8) @(posedge clk);
        chk({6'h0, op_ready, bus_ready}, 8'h00);
        chk({7'h0, bus_grant_out}, 8'h01);
        chk(processor_condition_register & 8'hC7, st & 8'hC7);
        run_stop_input <= 1'h1;
    endtask
    task automatic t_abort;
        op(OP_COPY_ACC_TO_STATUS, 8'h07, 8'h00);
        active_low_reset <= 1'h0;
        repeat (10) @(posedge clk);
        chk({5'h0, flag_pins}, 8'h00);
        active_low_reset <= 1'h1;
        op(OP_COPY_STATUS_TO_ACC, 8'h00, 8'h00);
        chk(rsp.acc & 8'hCF, 8'h00);
    endtask
    task automatic finish_test;
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {reset, active_low_reset, run_stop_input, bus_grant_in} = 4'hF;
        {sense_a_pin, sense_b_pin, serial_in_pin, stall} = 4'h0;
        {op_valid, bus_valid} = 2'h0;
        op_req = '0;
        bus_req = '0;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        t_sense_int;
        t_arith;
        t_serial;
        t_bus;
        t_stop;
        t_abort;
        finish_test;
    end
endmodule
`default_nettype wire

// >>> pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A bit counts only once two settled stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (reset) begin
                    level_out[i] <= 1'b0;
                end else if (stage2_reg[i] == stage3_reg[i]) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
